// >>> logic/csc_clock_control.sv
// Clock source selection, start-up delay and clock-domain gating.
// Assumes src_tick_i pulses once per cycle of the selected source and
// wdt_tick_i once per watchdog oscillator cycle, both synchronous to clk_i.
`timescale 1ns/1ps
`default_nettype none

// How it works
// - Four-bit source fuse picks crystal, low-frequency, RC or external; others reserved.
// - A fuse bit reading one is unprogrammed, zero is programmed.
// - Wake from power-down or power-save waits source cycles before running.
// - Reset start adds 0, 4,096 or 65,536 watchdog cycles of delay.
// - Shipped fuses: RC source, start-up 10, divide by eight programmed.
// - Unused module clocks are halted according to the sleep mode.
// - Core clock halted means the core performs no operations.
// - Peripheral clock halted leaves some external interrupts on async detection.
// - Start-condition detector runs asynchronously while peripheral clock is halted.
// - Program memory clock runs together with the core clock.
// - Async timer domain keeps timer and LCD running during sleep except power-down and standby.
// - Converter domain keeps running in noise reduction while core and peripheral clocks halt.
module csc_clock_control #(
    parameter int WAKE_SRC_CYCLES = 1024,
    parameter int WDT_SHORT       = csc_pkg::WDT_SHORT_CYCLES,
    parameter int WDT_LONG        = csc_pkg::WDT_LONG_CYCLES
) (
    // Clock, reset, enable
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        ce_i,
    // Wishbone slave
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    // Oscillator ticks and wake-up
    input  wire logic        src_tick_i,
    input  wire logic        wdt_tick_i,
    input  wire logic        wake_i,
    // Clock domain enables
    output logic             core_clock_en_o,
    output logic             peripheral_clock_en_o,
    output logic             program_memory_clock_en_o,
    output logic             async_timer_clock_en_o,
    output logic             converter_clock_en_o,
    // Async detection and generator setup
    output logic             async_irq_detect_o,
    output logic             start_condition_async_o,
    output logic             core_run_o,
    output logic      [1:0]  source_class_o,
    output logic      [3:0]  prescale_o
);

    initial begin
        if (WAKE_SRC_CYCLES < 1 || WAKE_SRC_CYCLES >= (1 << csc_pkg::CNT_W))
            $error("WAKE_SRC_CYCLES out of range");
        if (WDT_SHORT < 1 || WDT_LONG < 1 || WDT_LONG > (1 << csc_pkg::CNT_W) - 1)
            $error("watchdog delay out of range");
    end

    localparam logic [csc_pkg::CNT_W-1:0] WAKE_N  = csc_pkg::CNT_W'(WAKE_SRC_CYCLES);
    localparam logic [csc_pkg::CNT_W-1:0] SHORT_N = csc_pkg::CNT_W'(WDT_SHORT);
    localparam logic [csc_pkg::CNT_W-1:0] LONG_N  = csc_pkg::CNT_W'(WDT_LONG);

    // Registers
    logic [3:0]                 src_sel_q;
    logic [1:0]                 sut_sel_q;
    logic                       div8_q;
    logic [3:0]                 act_src_q;
    logic [1:0]                 act_sut_q;
    logic                       act_div8_q;
    csc_pkg::csc_mode_type      mode_q;
    csc_pkg::csc_state_type     state_q;
    logic [csc_pkg::CNT_W-1:0]  cnt_q;
    logic                       ack_q;
    logic [31:0]                dat_q;
    logic                       restart_q;

    // Bus decode
    logic       req;
    logic       wr_lo;
    logic       hit_fuse;
    logic       hit_ctrl;
    logic       hit_stat;
    logic       hit_cnt;
    logic       sleep_go;
    logic       restart_go;
    logic       src_reserved;
    logic [1:0] src_class;
    logic [csc_pkg::CNT_W-1:0] reset_n;
    logic       deep_mode;

    assign req      = wb_cyc_i && wb_stb_i && !ack_q;
    assign wr_lo    = req && wb_we_i && wb_sel_i[0];
    assign hit_fuse = wb_adr_i == csc_pkg::FUSE_OFS;
    assign hit_ctrl = wb_adr_i == csc_pkg::CTRL_OFS;
    assign hit_stat = wb_adr_i == csc_pkg::STATUS_OFS;
    assign hit_cnt  = wb_adr_i == csc_pkg::COUNT_OFS;
    assign sleep_go   = wr_lo && hit_ctrl && wb_dat_i[csc_pkg::SLEEP_BIT];
    assign restart_go = wr_lo && hit_ctrl && wb_dat_i[csc_pkg::RESTART_BIT];

    always_comb begin
        src_reserved = 1'b0;
        src_class    = csc_pkg::CLS_RC;
        if (act_src_q >= csc_pkg::SRC_CRYSTAL_MIN) begin
            src_class = csc_pkg::CLS_CRYSTAL;
        end else if (act_src_q == csc_pkg::SRC_LOWFREQ_A ||
                     act_src_q == csc_pkg::SRC_LOWFREQ_B) begin
            src_class = csc_pkg::CLS_LOWFREQ;
        end else if (act_src_q == csc_pkg::SRC_RC) begin
            src_class = csc_pkg::CLS_RC;
        end else if (act_src_q == csc_pkg::SRC_EXT) begin
            src_class = csc_pkg::CLS_EXT;
        end else begin
            src_reserved = 1'b1;
        end
    end

    always_comb begin
        if (act_sut_q == csc_pkg::SUT_NONE) begin
            reset_n = '0;
        end else if (act_sut_q == csc_pkg::SUT_SHORT) begin
            reset_n = SHORT_N;
        end else begin
            reset_n = LONG_N;
        end
    end

    assign deep_mode = mode_q == csc_pkg::MODE_POWER_DOWN ||
                       mode_q == csc_pkg::MODE_POWER_SAVE ||
                       mode_q == csc_pkg::MODE_STANDBY;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            src_sel_q <= csc_pkg::SRC_SHIPPED;
            sut_sel_q <= csc_pkg::SUT_SHIPPED;
            div8_q    <= csc_pkg::DIV8_SHIPPED;
        end else if (ce_i && wr_lo && hit_fuse) begin
            src_sel_q <= wb_dat_i[csc_pkg::SRC_LSB +: 4];
            sut_sel_q <= wb_dat_i[csc_pkg::SUT_LSB +: 2];
            div8_q    <= wb_dat_i[csc_pkg::DIV8_BIT];
        end
    end

    // Fuses take effect only at a start-up, as real fuses are read at reset
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            restart_q <= 1'b1;
        end else if (ce_i) begin
            restart_q <= restart_go;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            act_src_q  <= csc_pkg::SRC_SHIPPED;
            act_sut_q  <= csc_pkg::SUT_SHIPPED;
            act_div8_q <= csc_pkg::DIV8_SHIPPED;
        end else if (ce_i && restart_q) begin
            act_src_q  <= src_sel_q;
            act_sut_q  <= sut_sel_q;
            act_div8_q <= div8_q;
        end
    end

    // Sleep mode register
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            mode_q <= csc_pkg::MODE_IDLE;
        end else if (ce_i && wr_lo && hit_ctrl && state_q == csc_pkg::ST_RUN) begin
            mode_q <= csc_pkg::csc_mode_type'(wb_dat_i[csc_pkg::MODE_LSB +: 3]);
        end
    end

    // Start-up and sleep sequencer
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_q <= csc_pkg::ST_RESET_DLY;
            cnt_q   <= '0;
        end else if (ce_i) begin
            if (restart_q) begin
                state_q <= csc_pkg::ST_RESET_DLY;
                cnt_q   <= '0;
            end else begin
                unique case (state_q)
                    csc_pkg::ST_RESET_DLY: begin
                        if (cnt_q >= reset_n) begin
                            state_q <= src_reserved ? csc_pkg::ST_HOLD : csc_pkg::ST_SRC_DLY;
                            cnt_q   <= '0;
                        end else if (wdt_tick_i) begin
                            cnt_q <= cnt_q + 1'b1;
                        end
                    end
                    csc_pkg::ST_SRC_DLY: begin
                        if (cnt_q >= WAKE_N) begin
                            state_q <= csc_pkg::ST_RUN;
                            cnt_q   <= '0;
                        end else if (src_tick_i) begin
                            cnt_q <= cnt_q + 1'b1;
                        end
                    end
                    csc_pkg::ST_RUN: begin
                        if (sleep_go) begin
                            state_q <= csc_pkg::ST_SLEEP;
                        end
                    end
                    csc_pkg::ST_SLEEP: begin
                        if (wake_i) begin
                            state_q <= deep_mode ? csc_pkg::ST_SRC_DLY : csc_pkg::ST_RUN;
                            cnt_q   <= '0;
                        end
                    end
                    csc_pkg::ST_HOLD: begin
                        state_q <= csc_pkg::ST_HOLD;
                    end
                    default: begin
                        state_q <= csc_pkg::ST_RESET_DLY;
                        cnt_q   <= '0;
                    end
                endcase
            end
        end
    end

    // Clock gating per sleep mode
    logic running;
    logic asleep;
    assign running = state_q == csc_pkg::ST_RUN;
    assign asleep  = state_q == csc_pkg::ST_SLEEP;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            core_clock_en_o           <= 1'b0;
            program_memory_clock_en_o <= 1'b0;
            peripheral_clock_en_o     <= 1'b0;
            async_timer_clock_en_o    <= 1'b0;
            converter_clock_en_o      <= 1'b0;
            core_run_o                <= 1'b0;
        end else if (ce_i) begin
            core_clock_en_o           <= running;
            core_run_o                <= running;
            program_memory_clock_en_o <= running;
            // Peripheral clock only in idle sleep
            peripheral_clock_en_o     <= running ||
                                         (asleep && mode_q == csc_pkg::MODE_IDLE);
            // Async timer runs except power-down and standby
            async_timer_clock_en_o    <= running ||
                                         (asleep && mode_q != csc_pkg::MODE_POWER_DOWN &&
                                          mode_q != csc_pkg::MODE_STANDBY);
            // Converter runs in idle and noise reduction
            converter_clock_en_o      <= running ||
                                         (asleep && (mode_q == csc_pkg::MODE_IDLE ||
                                          mode_q == csc_pkg::MODE_NOISE_RED));
        end
    end

    // Async interrupt detect while peripheral clock halted
    assign async_irq_detect_o      = !peripheral_clock_en_o;
    assign start_condition_async_o = !peripheral_clock_en_o;

    // Programmed fuse means divide by eight
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            prescale_o     <= csc_pkg::PRESCALE_DIV8;
            source_class_o <= csc_pkg::CLS_RC;
        end else if (ce_i) begin
            prescale_o     <= (act_div8_q == csc_pkg::FUSE_PROGRAMMED) ?
                              csc_pkg::PRESCALE_DIV8 : csc_pkg::PRESCALE_DIV1;
            source_class_o <= src_class;
        end
    end

    // Wishbone answer: one wait state, unmapped reads give zero
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_q <= 1'b0;
            dat_q <= '0;
        end else if (ce_i) begin
            ack_q <= req;
            dat_q <= '0;
            if (req && !wb_we_i) begin
                if (hit_fuse) begin
                    dat_q[csc_pkg::SRC_LSB +: 4] <= src_sel_q;
                    dat_q[csc_pkg::SUT_LSB +: 2] <= sut_sel_q;
                    dat_q[csc_pkg::DIV8_BIT]     <= div8_q;
                end else if (hit_ctrl) begin
                    dat_q[csc_pkg::MODE_LSB +: 3] <= mode_q;
                end else if (hit_stat) begin
                    dat_q[4:0] <= state_q;
                    dat_q[5]   <= src_reserved;
                    dat_q[7:6] <= src_class;
                end else if (hit_cnt) begin
                    dat_q[csc_pkg::CNT_W-1:0] <= cnt_q;
                end
            end
        end
    end

    assign wb_ack_o = ack_q;
    assign wb_dat_o = dat_q;

endmodule

`default_nettype wire

// >>> logic/csc_pkg.sv
// Constants, register map and types of the clock source and start-up control.
// Assumes byte-addressed classic Wishbone with 32-bit data.
package csc_pkg;

    // Register byte offsets
    localparam logic [7:0] FUSE_OFS   = 8'h00;
    localparam logic [7:0] CTRL_OFS   = 8'h04;
    localparam logic [7:0] STATUS_OFS = 8'h08;
    localparam logic [7:0] COUNT_OFS  = 8'h0C;

    // Fuse register fields (0 = programmed, 1 = unprogrammed)
    localparam int SRC_LSB  = 0;
    localparam int SUT_LSB  = 4;
    localparam int DIV8_BIT = 6;

    // As-shipped fuses: RC source, longest start-up, divide by eight programmed
    localparam logic [3:0] SRC_SHIPPED  = 4'h2;
    localparam logic [1:0] SUT_SHIPPED  = 2'h2;
    localparam logic       DIV8_SHIPPED = 1'b0;
    localparam logic       FUSE_PROGRAMMED = 1'b0;

    // Control register fields
    localparam int MODE_LSB    = 0;
    localparam int SLEEP_BIT   = 3;
    localparam int RESTART_BIT = 4;

    // Source classes reported in status
    localparam logic [1:0] CLS_CRYSTAL = 2'h0;
    localparam logic [1:0] CLS_LOWFREQ = 2'h1;
    localparam logic [1:0] CLS_RC      = 2'h2;
    localparam logic [1:0] CLS_EXT     = 2'h3;

    // Source select codes
    localparam logic [3:0] SRC_CRYSTAL_MIN = 4'h8;
    localparam logic [3:0] SRC_LOWFREQ_A   = 4'h6;
    localparam logic [3:0] SRC_LOWFREQ_B   = 4'h7;
    localparam logic [3:0] SRC_RC          = 4'h2;
    localparam logic [3:0] SRC_EXT         = 4'h0;

    // Start-up select codes
    localparam logic [1:0] SUT_NONE  = 2'h0;
    localparam logic [1:0] SUT_SHORT = 2'h1;

    // Watchdog oscillator cycles of the reset delay
    localparam int WDT_SHORT_CYCLES = 4096;
    localparam int WDT_LONG_CYCLES  = 65536;
    localparam int CNT_W            = 17;

    // Prescale factors reported to the clock generator
    localparam logic [3:0] PRESCALE_DIV8 = 4'h8;
    localparam logic [3:0] PRESCALE_DIV1 = 4'h1;

    typedef enum logic [2:0] {
        MODE_IDLE       = 3'h0,
        MODE_NOISE_RED  = 3'h1,
        MODE_POWER_DOWN = 3'h2,
        MODE_POWER_SAVE = 3'h3,
        MODE_STANDBY    = 3'h6
    } csc_mode_type;

    typedef enum logic [4:0] {
        ST_RESET_DLY = 5'b00001,
        ST_SRC_DLY   = 5'b00010,
        ST_RUN       = 5'b00100,
        ST_SLEEP     = 5'b01000,
        ST_HOLD      = 5'b10000
    } csc_state_type;

endpackage

// >>> tb/csc_clock_control_sva.sv
// Port checker for the clock source and start-up control.
// Assumes ce_i is held high, so every registered output moves each edge.
`timescale 1ns/1ps
`default_nettype none
module csc_clock_control_sva (
    input wire logic        clk_i,
    input wire logic        rst_i,
    input wire logic        wb_cyc_i,
    input wire logic        wb_stb_i,
    input wire logic        wb_we_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic        wb_ack_o,
    input wire logic        core_clock_en_o,
    input wire logic        peripheral_clock_en_o,
    input wire logic        program_memory_clock_en_o,
    input wire logic        async_timer_clock_en_o,
    input wire logic        converter_clock_en_o,
    input wire logic        async_irq_detect_o,
    input wire logic        start_condition_async_o,
    input wire logic        core_run_o,
    input wire logic [1:0]  source_class_o,
    input wire logic [3:0]  prescale_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    chk_ack_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("ack missing one cycle after request");
    chk_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    chk_dat_idle: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
        else $error("read data outside ack cycle");
    chk_reset_values: assert property ($past(rst_i) |-> prescale_o == 4'h8 && source_class_o == 2'h2 && !core_run_o && !core_clock_en_o)
        else $error("wrong values after reset");
    chk_irq_async: assert property (async_irq_detect_o == !peripheral_clock_en_o)
        else $error("async interrupt detect not tied to peripheral clock");
    chk_start_async: assert property (start_condition_async_o == !peripheral_clock_en_o)
        else $error("start detect not tied to peripheral clock");
    chk_flash_core: assert property (program_memory_clock_en_o == core_clock_en_o)
        else $error("program memory clock differs from core clock");
    chk_conv_async: assert property (converter_clock_en_o |-> async_timer_clock_en_o)
        else $error("converter clock on with async timer clock off");
    chk_peri_conv: assert property (peripheral_clock_en_o |-> converter_clock_en_o)
        else $error("peripheral clock on with converter clock off");
    chk_run_clocks: assert property (core_run_o && $past(core_run_o) |-> core_clock_en_o && peripheral_clock_en_o)
        else $error("core runs with clocks halted");

    cover property (wb_ack_o && wb_we_i);
    cover property ($rose(core_run_o));
    cover property ($past(core_run_o) && !async_timer_clock_en_o && !core_clock_en_o);
endmodule

bind csc_clock_control csc_clock_control_sva i_sva (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .core_clock_en_o(core_clock_en_o), .peripheral_clock_en_o(peripheral_clock_en_o),
    .program_memory_clock_en_o(program_memory_clock_en_o),
    .async_timer_clock_en_o(async_timer_clock_en_o), .converter_clock_en_o(converter_clock_en_o),
    .async_irq_detect_o(async_irq_detect_o), .start_condition_async_o(start_condition_async_o),
    .core_run_o(core_run_o), .source_class_o(source_class_o), .prescale_o(prescale_o)
);
`default_nettype wire

// >>> tb/csc_osc_model.sv
// Oscillator model: source and watchdog ticks, delivered on request.
// Assumes one caller at a time; a gap of idle cycles models a slow source.
`timescale 1ns/1ps
`default_nettype none
module csc_osc_model (
    input  wire logic clk_i,
    output var  logic src_tick_o,
    output var  logic wdt_tick_o
);
    initial begin
        src_tick_o = 1'b0;
        wdt_tick_o = 1'b0;
    end

    // Ticks stay one cycle wide so none is counted twice
    task automatic pulse(input bit wdt, input int n, input int gap);
        for (int i = 0; i < n; i++) begin
            repeat (gap) @(posedge clk_i);
            @(posedge clk_i);
            src_tick_o <= !wdt;
            wdt_tick_o <= wdt;
            @(posedge clk_i);
            src_tick_o <= 1'b0;
            wdt_tick_o <= 1'b0;
        end
    endtask
endmodule
`default_nettype wire

// >>> tb/csc_clock_control_tb_top.sv
// Bench for the clock source and start-up control.
// Assumes shortened start-up counts; ticks come from the oscillator model.
`timescale 1ns/1ps
`default_nettype none
module csc_clock_control_tb_top;
    localparam int W  = 4;
    localparam int WS = 3;
    localparam int WL = 6;
    logic        clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wake_i, src_tick_i, wdt_tick_i;
    logic [7:0]  wb_adr_i;
    logic [3:0]  wb_sel_i, prescale_o;
    logic [31:0] wb_dat_i, wb_dat_o, rd;
    logic        wb_ack_o, core_en, peri_en, flash_en, asy_en, conv_en, irq_det, st_det, core_run_o;
    logic [1:0]  source_class_o;
    int          fail_count, n_tests;

    csc_clock_control #(.WAKE_SRC_CYCLES(W), .WDT_SHORT(WS), .WDT_LONG(WL)) i_csc_clock_control (
        .clk_i(clk_i), .rst_i(rst_i), .ce_i(1'b1), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
        .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .src_tick_i(src_tick_i),
        .wdt_tick_i(wdt_tick_i), .wake_i(wake_i), .core_clock_en_o(core_en),
        .peripheral_clock_en_o(peri_en), .program_memory_clock_en_o(flash_en),
        .async_timer_clock_en_o(asy_en), .converter_clock_en_o(conv_en),
        .async_irq_detect_o(irq_det), .start_condition_async_o(st_det),
        .core_run_o(core_run_o), .source_class_o(source_class_o), .prescale_o(prescale_o));
    csc_osc_model i_osc (.clk_i(clk_i), .src_tick_o(src_tick_i), .wdt_tick_o(wdt_tick_i));

    initial begin
        clk_i = 1'b0;
        forever #4 clk_i = ~clk_i;
    end

    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_tests++;
        if (got !== exp) begin
            fail_count++;
            $display("ERROR %s expected %0h seen %0h", what, exp, got);
        end
    endtask

    task automatic print_verdict;
        $display("comparisons %0d mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    // Classic single cycle; read data is taken at the ack edge
    task automatic wb_xfer(input logic we, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i  <= we;
        wb_adr_i <= a;
        wb_dat_i <= d;
        do begin
            @(posedge clk_i);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 16);
        rd = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        wb_we_i  <= 1'b0;
        check("bus ack", 32'h1, 32'(wb_ack_o));
    endtask

    function automatic logic [1:0] cls(input logic [3:0] c);
        if (c[3]) return 2'h0;
        if (c[3:1] == 3'h3) return 2'h1;
        if (c == 4'h2) return 2'h2;
        return 2'h3;
    endfunction

    task automatic start_up(input logic [6:0] f, input bit restart);
        int  n;
        int  g;
        bit  rsv;
        g   = $urandom_range(2);
        rsv = !(f[3] || f[3:1] == 3'h3 || f[3:0] == 4'h2 || f[3:0] == 4'h0);
        n   = (f[5:4] == 2'h0) ? 0 : (f[5:4] == 2'h1) ? WS : WL;
        if (restart) begin
            wb_xfer(1'b1, csc_pkg::FUSE_OFS, 32'(f));
            wb_xfer(1'b0, csc_pkg::FUSE_OFS, 32'h0);
            check("fuse", 32'(f), rd);
            wb_xfer(1'b1, csc_pkg::CTRL_OFS, 32'h10);
        end
        repeat (3) @(posedge clk_i);
        if (n > 0) begin
            i_osc.pulse(1'b1, n - 1, g);
            wb_xfer(1'b0, csc_pkg::STATUS_OFS, 32'h0);
            check("reset delay", 32'h1, 32'(rd[4:0]));
            i_osc.pulse(1'b1, 1, g);
        end
        wb_xfer(1'b0, csc_pkg::STATUS_OFS, 32'h0);
        check("status", rsv ? 32'h30 : 32'h02, 32'(rd[5:0]));
        i_osc.pulse(1'b0, W - 1, g);
        check("run early", 32'h0, 32'(core_run_o));
        i_osc.pulse(1'b0, 1, g);
        repeat (3) @(posedge clk_i);
        check("run", 32'(!rsv), 32'(core_run_o));
        if (!rsv) begin
            check("class", 32'(cls(f[3:0])), 32'(source_class_o));
            check("prescale", f[6] ? 32'h1 : 32'h8, 32'(prescale_o));
            check("run clocks", 32'h1F, 32'({core_en, flash_en, peri_en, asy_en, conv_en}));
        end
        $display("start-up fuses %0h done", f);
    endtask

    task automatic sleep_wake(input logic [2:0] m, input logic [2:0] on);
        wb_xfer(1'b1, csc_pkg::CTRL_OFS, 32'(m));
        wb_xfer(1'b0, csc_pkg::CTRL_OFS, 32'h0);
        check("mode", 32'(m), 32'(rd[2:0]));
        wb_xfer(1'b1, csc_pkg::CTRL_OFS, 32'(m) | 32'h8);
        repeat (3) @(posedge clk_i);
        check("sleep gates", 32'({2'b00, on, !on[2], !on[2], 1'b0}),
              32'({core_en, flash_en, peri_en, asy_en, conv_en, irq_det, st_det, core_run_o}));
        wake_i <= 1'b1;
        @(posedge clk_i);
        wake_i <= 1'b0;
        if (m[1]) begin
            wb_xfer(1'b0, csc_pkg::STATUS_OFS, 32'h0);
            check("wake delay", 32'h2, 32'(rd[4:0]));
            i_osc.pulse(1'b0, W - 1, 1);
            check("wake early", 32'h0, 32'(core_run_o));
            i_osc.pulse(1'b0, 1, 1);
        end
        repeat (3) @(posedge clk_i);
        check("woken", 32'h3F, 32'({core_run_o, core_en, flash_en, peri_en, asy_en, conv_en}));
        $display("sleep mode %0d done", m);
    endtask

    initial begin
        logic [2:0] r;
        logic [2:0] modes [5];
        logic [2:0] gates [5];
        modes = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h6};
        gates = '{3'b111, 3'b011, 3'b000, 3'b010, 3'b000};
        {rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wake_i} = 5'h10;
        {wb_adr_i, wb_dat_i, wb_sel_i} = {40'h0, 4'hF};
        void'($urandom(47163));
        repeat (8) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        check("reset outs", 32'h44, 32'({prescale_o, source_class_o, core_run_o}));
        wb_xfer(1'b0, csc_pkg::FUSE_OFS, 32'h0);
        check("shipped fuses", 32'h22, rd);
        wb_xfer(1'b0, 8'h10, 32'h0);
        check("unmapped", 32'h0, rd);
        start_up(7'h22, 1'b0);
        for (int c = 0; c < 16; c++) begin
            r = 3'($urandom);
            start_up({r, 4'(c)}, 1'b1);
        end
        for (int i = 0; i < 5; i++) begin
            sleep_wake(modes[i], gates[i]);
        end
        print_verdict();
    end

    initial begin
        #(8 * 20000);
        fail_count++;
        print_verdict();
    end
endmodule
`default_nettype wire
